// file: design/io_port_with_peripheral_irq.v
// The implementer's own choices: the placing of the registers and the plain strobed port.
`include "io_port_defines.vh"

module io_port_with_peripheral_irq (
    // clock and reset
    input  wire                clk,
    input  wire                rst,
    // register port
    input  wire [`ADDR_W-1:0]  addr,
    input  wire [15:0]         wdata,
    input  wire                wr,
    input  wire                rd,
    output reg  [15:0]         rdata,
    // shared pins (input, output, output enable low = driving)
    input  wire [8:0]          pin_in,
    output reg  [8:0]          pin_out,
    output reg  [8:0]          pin_oe_n,
    // alternate functions to and from pins
    input  wire [8:0]          alt_out,
    input  wire [8:0]          alt_drive,
    output reg  [8:0]          alt_in,
    // peripheral interrupt sources
    input  wire                pwm_sync_pulse,
    input  wire                pwm_shutdown_input_n,
    input  wire                overcurrent,
    // merged interrupt to the core, active low
    output reg                 peripheral_irq_line_n
);

    // ------------------------------------------------------------
    // configuration registers and sticky flags
    // ------------------------------------------------------------
    reg  [7:0] func_sel_r;
    reg        upper_func_r;
    reg  [8:0] dir_r;
    reg  [8:0] out_data_r;
    reg  [8:0] irq_en_r;
    reg  [8:0] chg_flag_r;
    reg        trip_flag_r;
    reg        sync_flag_r;

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    reg  [8:0] pin_s1_r;
    reg  [8:0] pin_s2_r;
    reg  [8:0] pin_prev_r;
    reg  [2:0] src_s1_r;
    reg  [2:0] src_s2_r;
    reg  [2:0] src_prev_r;

    wire [8:0] gpio_use;
    wire [8:0] src_en;
    wire [8:0] chg_event;
    wire       sync_event;
    wire       trip_event;
    wire       soft_trip_wr;
    wire       rd_lower_flags;
    wire       rd_upper_flag;
    wire       rd_periph;
    wire       wr_hit;

    assign gpio_use = {upper_func_r, func_sel_r};

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pin_s1_r   <= `PIN_SYNC_RST;
            pin_s2_r   <= `PIN_SYNC_RST;
            pin_prev_r <= `PIN_SYNC_RST;
            src_s1_r   <= `SRC_SYNC_RST;
            src_s2_r   <= `SRC_SYNC_RST;
            src_prev_r <= `SRC_SYNC_RST;
        end
        else
        begin
            pin_s1_r   <= pin_in;
            pin_s2_r   <= pin_s1_r;
            pin_prev_r <= pin_s2_r;
            src_s1_r   <= {overcurrent, pwm_shutdown_input_n,
                           pwm_sync_pulse};
            src_s2_r   <= src_s1_r;
            src_prev_r <= src_s2_r;
        end
    end

    // ------------------------------------------------------------
    // per line source qualification and edge detection
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 9; g = g + 1)
        begin : g_line
            assign src_en[g]    = irq_en_r[g] & gpio_use[g] & ~dir_r[g];
            assign chg_event[g] = src_en[g] &
                                  (pin_s2_r[g] ^ pin_prev_r[g]);
        end
    endgenerate

    assign sync_event = src_s2_r[0] & ~src_prev_r[0];
    assign trip_event = (~src_s2_r[1] & src_prev_r[1]) |
                        (src_s2_r[2] & ~src_prev_r[2]) |
                        soft_trip_wr;

    // ------------------------------------------------------------
    // register access decode
    // ------------------------------------------------------------
    assign wr_hit         = wr;
    assign soft_trip_wr   = wr_hit & (addr == `OFS_SOFT_TRIP);
    assign rd_lower_flags = rd & (addr == `OFS_LOWER_FLAGS);
    assign rd_upper_flag  = rd & (addr == `OFS_UPPER_FLAG);
    assign rd_periph      = rd & (addr == `OFS_PERIPH_FLAGS);

    // ------------------------------------------------------------
    // per register write enables
    // ------------------------------------------------------------
    wire       wr_func_sel;
    wire       wr_lower_dir;
    wire       wr_upper_dir;
    wire       wr_lower_data;
    wire       wr_upper_data;
    wire       wr_lower_en;
    wire       wr_upper_en;

    assign wr_func_sel   = wr_hit & (addr == `OFS_FUNC_SELECT);
    assign wr_lower_dir  = wr_hit & (addr == `OFS_LOWER_DIR);
    assign wr_upper_dir  = wr_hit & (addr == `OFS_UPPER_DIR);
    assign wr_lower_data = wr_hit & (addr == `OFS_LOWER_DATA);
    assign wr_upper_data = wr_hit & (addr == `OFS_UPPER_DATA);
    assign wr_lower_en   = wr_hit & (addr == `OFS_LOWER_IRQ_EN);
    assign wr_upper_en   = wr_hit & (addr == `OFS_UPPER_IRQ_EN);

    // ------------------------------------------------------------
    // function select, line eight shares the upper data register
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            func_sel_r   <= `FUNC_SELECT_RST;
            upper_func_r <= `UPPER_FUNC_RST;
        end
        else
        begin
            if (wr_func_sel)
            begin
                func_sel_r <= wdata[7:0];
            end
            if (wr_upper_data)
            begin
                upper_func_r <= wdata[`UPPER_FUNC_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // direction, set bit drives the line
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            dir_r <= {`UPPER_RST, `LOWER_RST};
        end
        else
        begin
            if (wr_lower_dir)
            begin
                dir_r[7:0] <= wdata[7:0];
            end
            if (wr_upper_dir)
            begin
                dir_r[8] <= wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // output latch, reads return the pin level instead
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            out_data_r <= {`UPPER_RST, `LOWER_RST};
        end
        else
        begin
            if (wr_lower_data)
            begin
                out_data_r[7:0] <= wdata[7:0];
            end
            if (wr_upper_data)
            begin
                out_data_r[8] <= wdata[`UPPER_DATA_BIT];
            end
        end
    end

    // ------------------------------------------------------------
    // change interrupt enables
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_en_r <= {`UPPER_RST, `LOWER_RST};
        end
        else
        begin
            if (wr_lower_en)
            begin
                irq_en_r[7:0] <= wdata[7:0];
            end
            if (wr_upper_en)
            begin
                irq_en_r[8] <= wdata[0];
            end
        end
    end

    // ------------------------------------------------------------
    // flag next values: a new event wins over a read clear
    // ------------------------------------------------------------
    reg  [8:0] chg_flag_nxt;
    reg        trip_flag_nxt;
    reg        sync_flag_nxt;

    always @*
    begin
        chg_flag_nxt[7:0] = (rd_lower_flags ? `LOWER_RST : chg_flag_r[7:0])
                            | chg_event[7:0];
        chg_flag_nxt[8]   = (rd_upper_flag ? `UPPER_RST : chg_flag_r[8])
                            | chg_event[8];
        trip_flag_nxt     = (rd_periph ? 1'b0 : trip_flag_r)
                            | trip_event;
        sync_flag_nxt     = (rd_periph ? 1'b0 : sync_flag_r)
                            | sync_event;
    end

    // ------------------------------------------------------------
    // sticky flags
    // ------------------------------------------------------------
    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            chg_flag_r  <= 9'h000;
            trip_flag_r <= 1'b0;
            sync_flag_r <= 1'b0;
        end
        else
        begin
            chg_flag_r  <= chg_flag_nxt;
            trip_flag_r <= trip_flag_nxt;
            sync_flag_r <= sync_flag_nxt;
        end
    end

    // ------------------------------------------------------------
    // read data, one cycle after the strobe
    // ------------------------------------------------------------
    reg [15:0] rdata_nxt;

    always @*
    begin
        rdata_nxt = `DATA_ZERO;
        case (addr)
            `OFS_FUNC_SELECT:
            begin
                rdata_nxt[7:0] = func_sel_r;
            end
            `OFS_LOWER_DIR:
            begin
                rdata_nxt[7:0] = dir_r[7:0];
            end
            `OFS_UPPER_DIR:
            begin
                rdata_nxt[0] = dir_r[8];
            end
            `OFS_LOWER_DATA:
            begin
                rdata_nxt[7:0] = pin_s2_r[7:0];
            end
            `OFS_UPPER_DATA:
            begin
                rdata_nxt[`UPPER_DATA_BIT] = pin_s2_r[8];
                rdata_nxt[`UPPER_FUNC_BIT] = upper_func_r;
            end
            `OFS_LOWER_IRQ_EN:
            begin
                rdata_nxt[7:0] = irq_en_r[7:0];
            end
            `OFS_UPPER_IRQ_EN:
            begin
                rdata_nxt[0] = irq_en_r[8];
            end
            `OFS_LOWER_FLAGS:
            begin
                rdata_nxt[7:0] = chg_flag_r[7:0];
            end
            `OFS_UPPER_FLAG:
            begin
                rdata_nxt[0] = chg_flag_r[8];
            end
            `OFS_PERIPH_FLAGS:
            begin
                rdata_nxt[`PFLAG_TRIP_BIT] = trip_flag_r;
                rdata_nxt[`PFLAG_SYNC_BIT] = sync_flag_r;
            end
            default:
            begin
                rdata_nxt = `DATA_ZERO;
            end
        endcase
    end

    // ------------------------------------------------------------
    // registered outputs
    // ------------------------------------------------------------
    integer i;

    always @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            rdata                 <= `DATA_ZERO;
            pin_out               <= `PIN_OUT_RST;
            pin_oe_n              <= `PIN_OE_N_RST;
            alt_in                <= `PIN_OUT_RST;
            peripheral_irq_line_n <= `IRQ_LINE_N_RST;
        end
        else
        begin
            rdata <= rd ? rdata_nxt : `DATA_ZERO;
            for (i = 0; i < 9; i = i + 1)
            begin
                // mux each pin between io line and its alternate
                pin_out[i]  <= gpio_use[i] ? out_data_r[i] : alt_out[i];
                pin_oe_n[i] <= gpio_use[i] ? ~dir_r[i] : ~alt_drive[i];
                alt_in[i]   <= gpio_use[i] ? 1'b0 : pin_s2_r[i];
            end
            // level stays low while anything pending
            peripheral_irq_line_n <= ~(trip_flag_r | sync_flag_r |
                                       (|chg_flag_r));
        end
    end

endmodule // io_port_with_peripheral_irq

// file: design/io_port_defines.vh
`ifndef IO_PORT_DEFINES_VH
`define IO_PORT_DEFINES_VH

// ----------------------------------------------------------------
// register offsets (word addresses on the register port)
// ----------------------------------------------------------------
`define ADDR_W              7
`define OFS_LOWER_DIR       7'h04
`define OFS_LOWER_DATA      7'h05
`define OFS_LOWER_IRQ_EN    7'h06
`define OFS_LOWER_FLAGS     7'h07
`define OFS_PERIPH_FLAGS    7'h17
`define OFS_UPPER_DIR       7'h44
`define OFS_UPPER_DATA      7'h45
`define OFS_UPPER_IRQ_EN    7'h46
`define OFS_UPPER_FLAG      7'h47
`define OFS_FUNC_SELECT     7'h49
`define OFS_SOFT_TRIP       7'h61

// ----------------------------------------------------------------
// field positions and reset values
// ----------------------------------------------------------------
`define UPPER_DATA_BIT      0
`define UPPER_FUNC_BIT      1
`define PFLAG_TRIP_BIT      0
`define PFLAG_SYNC_BIT      1
`define FUNC_SELECT_RST     8'hFF
`define LOWER_RST           8'h00
`define UPPER_RST           1'b0
`define UPPER_FUNC_RST      1'b1
`define DATA_ZERO           16'h0000
`define PIN_SYNC_RST        9'h000
`define SRC_SYNC_RST        3'h2
`define PIN_OUT_RST         9'h000
`define PIN_OE_N_RST        9'h1FF
`define IRQ_LINE_N_RST      1'b1

`endif

// file: verification/pin_world.sv
module pin_world (
    // device side
    input  logic [8:0] pin_out,
    input  logic [8:0] pin_oe_n,
    // outside drivers, zero where undriven
    input  logic [8:0] ext,
    output logic [8:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // pin level
    // ----
    // pull-down leaves an undriven line low
    assign pin_in = (pin_out & ~pin_oe_n) | (ext & pin_oe_n);
endmodule // pin_world

// file: verification/io_port_monitor.sv
module io_port_monitor (
    // clock and reset
    input logic        clk,
    input logic        rst,
    // register port
    input logic [6:0]  addr,
    input logic        wr,
    input logic        rd,
    input logic [15:0] rdata,
    // interrupt sources and line
    input logic        pwm_sync_pulse,
    input logic        pwm_shutdown_input_n,
    input logic        overcurrent,
    input logic        peripheral_irq_line_n
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----
    // checks
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    property p_rd_idle;
        !$past(rd) |-> rdata == 16'h0000;
    endproperty
    a_rd_idle: assert property (p_rd_idle)
        else $error("rdata not idle");
    property p_unmapped;
        rd && addr == 7'h7F |=> rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_soft;
        wr && addr == 7'h61 |-> ##2 !peripheral_irq_line_n;
    endproperty
    a_soft: assert property (p_soft)
        else $error("soft trip gave no irq");
    property p_sync;
        $rose(pwm_sync_pulse) |-> ##[2:5] !peripheral_irq_line_n;
    endproperty
    a_sync: assert property (p_sync)
        else $error("sync gave no irq");
    property p_trip;
        $fell(pwm_shutdown_input_n) |-> ##[2:5] !peripheral_irq_line_n;
    endproperty
    a_trip: assert property (p_trip)
        else $error("trip pin gave no irq");
    property p_oc;
        $rose(overcurrent) |-> ##[2:5] !peripheral_irq_line_n;
    endproperty
    a_oc: assert property (p_oc)
        else $error("overcurrent gave no irq");
    property p_hold;
        !peripheral_irq_line_n && !rd && !$past(rd) |=>
            !peripheral_irq_line_n;
    endproperty
    a_hold: assert property (p_hold)
        else $error("irq released without read");
    property p_release;
        $rose(peripheral_irq_line_n) |-> $past(rd, 2);
    endproperty
    a_release: assert property (p_release)
        else $error("irq rose not after read");
    c_soft: cover property (wr && addr == 7'h61);
    c_sync: cover property ($rose(pwm_sync_pulse));
    c_rel: cover property ($rose(peripheral_irq_line_n));
endmodule // io_port_monitor

bind io_port_with_peripheral_irq io_port_monitor io_port_monitor_i (
    .clk, .rst, .addr, .wr, .rd, .rdata, .pwm_sync_pulse,
    .pwm_shutdown_input_n, .overcurrent, .peripheral_irq_line_n);

// file: verification/io_port_with_peripheral_irq_bench.sv
module io_port_with_peripheral_irq_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst, wr, rd, sy, tr_n, oc, irq_n;
    logic [6:0]  addr;
    logic [15:0] wdata, rdata;
    logic [8:0]  pin_in, pin_out, oe_n, a_out, a_drv, a_in, ext;
    int          err_total, n_tests;
    logic [6:0]  ra [8] = '{7'h49, 7'h45, 7'h04, 7'h44, 7'h06, 7'h46,
                            7'h05, 7'h7F};
    logic [15:0] rv [8] = '{16'h00FF, 16'h0002, 16'h0000, 16'h0000,
                            16'h0000, 16'h0000, 16'h0000, 16'h0000};
    io_port_with_peripheral_irq io_port_with_peripheral_irq_i (.clk, .rst,
        .addr, .wdata, .wr, .rd, .rdata, .pin_in, .pin_out,
        .pin_oe_n(oe_n), .alt_out(a_out), .alt_drive(a_drv), .alt_in(a_in),
        .pwm_sync_pulse(sy), .pwm_shutdown_input_n(tr_n), .overcurrent(oc),
        .peripheral_irq_line_n(irq_n));
    pin_world pin_world_i (.pin_out, .pin_oe_n(oe_n), .ext, .pin_in);
    always #50 clk = ~clk;
    task automatic close_out;
        if (err_total == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_tests++;
        if (g !== e)
        begin
            err_total++;
            $display("[ERR] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic wrr(input logic [6:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [6:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, e);
        @(posedge clk);
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    initial
    begin
        {clk, wr, rd, sy, oc, addr, wdata, a_out, a_drv, ext} = '0;
        {rst, tr_n} = 2'b11;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({7'h00, oe_n}, 16'h01FF);
        for (int i = 0; i < 8; i++)
            rdc(ra[i], rv[i]);
        ext <= 9'h042;
        wrr(7'h04, 16'h00A5);
        wrr(7'h05, 16'h0081);
        wrr(7'h44, 16'h0001);
        wrr(7'h45, 16'h0003);
        cyc(3);
        chk({7'h00, oe_n}, 16'h005A);
        chk({7'h00, pin_out & ~oe_n}, 16'h0181);
        rdc(7'h05, 16'h00C3);
        rdc(7'h45, 16'h0003);
        ext <= 9'h000;
        wrr(7'h04, 16'h0000);
        wrr(7'h44, 16'h0000);
        wrr(7'h49, 16'h00FD);
        wrr(7'h06, 16'h000F);
        wrr(7'h46, 16'h0001);
        for (int k = 0; k < 2; k++)
        begin
            ext <= k ? 9'h000 : 9'h123;
            cyc(6);
            chk({15'h0000, irq_n}, 16'h0000);
            chk({7'h00, a_in}, {14'h0000, !k, 1'b0});
            rdc(7'h07, 16'h0001);
            rdc(7'h07, 16'h0000);
            rdc(7'h47, 16'h0001);
            cyc(3);
            chk({15'h0000, irq_n}, 16'h0001);
        end
        for (int s = 0; s < 4; s++)
        begin
            case (s)
                0: sy <= 1'b1;
                1: tr_n <= 1'b0;
                2: oc <= 1'b1;
                default: wrr(7'h61, 16'h0000);
            endcase
            cyc(6);
            chk({15'h0000, irq_n}, 16'h0000);
            rdc(7'h17, s ? 16'h0001 : 16'h0002);
            {sy, tr_n, oc} <= 3'b010;
            cyc(6);
            chk({15'h0000, irq_n}, 16'h0001);
        end
        wrr(7'h45, 16'h0000);
        a_drv <= 9'h100;
        a_out <= 9'h100;
        cyc(3);
        chk({14'h0000, oe_n[8], pin_out[8]}, 16'h0001);
        close_out;
    end
    initial
    begin
        repeat (3000) @(posedge clk);
        err_total++;
        close_out;
    end
endmodule // io_port_with_peripheral_irq_bench
